/* fpg_gpio.sv */
`timescale 1ns/1ps
module fpg_gpio
	import fpg_pkg::*;
(
	input  wire logic                        clk_sys,
	input  wire logic                        reset_n,
	input  wire fpg_pkg::fpg_bus_type        bus,
	output logic [7:0]                       rdata,
	input  wire logic                        halt_req,
	input  wire logic [31:0]                 pin_in,
	output fpg_pkg::fpg_pins_type            pins,
	output logic                             power_down,
	output logic                             wake_pulse,
	output logic                             ext_irq_zero,
	output logic                             ext_irq_one,
	output logic [3:0]                       wdt_ctrl
);
	import fpg_pkg::*;

	logic [3:0][7:0] data_q, data_d;
	logic [3:0][7:0] dir_q, dir_d;
	logic [3:0][7:0] pu_q, pu_d;
	logic [7:0]      wake_q, wake_d;
	logic [7:0]      misc_q, misc_d;
	logic [7:0]      intc_q, intc_d;
	logic [31:0]     sync1_q, sync2_q;
	logic [7:0]      pa_prev_q, pa_prev_d;
	logic [7:0]      rdata_q, rdata_d;
	fpg_pwr_type     pwr_q, pwr_d;
	logic [7:0]      pa_fall;

	// port value as seen by a read: latch for outputs, pin for inputs
	function automatic logic [7:0] port_view(input logic [7:0] dat, input logic [7:0] dir,
		input logic [7:0] lvl);
		port_view = (dir & lvl) | (~dir & dat);
	endfunction

	// two-stage pin synchroniser
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			sync1_q <= 32'h0000_0000;
			sync2_q <= 32'h0000_0000;
		end else begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
		end
	end

	// register writes; single-bit ops arrive as full-byte writes after a read
	always_comb begin
		data_d = data_q;
		dir_d  = dir_q;
		pu_d   = pu_q;
		wake_d = wake_q;
		misc_d = misc_q;
		intc_d = intc_q;
		if (bus.wr_en) begin
			case (bus.addr)
				ADDR_PA_DATA: data_d[0] = bus.wdata;
				ADDR_PB_DATA: data_d[1] = bus.wdata;
				ADDR_PC_DATA: data_d[2] = bus.wdata;
				ADDR_PD_DATA: data_d[3] = bus.wdata;
				ADDR_PA_DIR:  dir_d[0]  = bus.wdata;
				ADDR_PB_DIR:  dir_d[1]  = bus.wdata;
				ADDR_PC_DIR:  dir_d[2]  = bus.wdata;
				ADDR_PD_DIR:  dir_d[3]  = bus.wdata;
				ADDR_PA_PU:   pu_d[0]   = bus.wdata;
				ADDR_PB_PU:   pu_d[1]   = bus.wdata;
				ADDR_PC_PU:   pu_d[2]   = bus.wdata;
				ADDR_PD_PU:   pu_d[3]   = bus.wdata;
				ADDR_PA_WAKE: wake_d    = bus.wdata;
				ADDR_MISC:    misc_d    = bus.wdata;
				ADDR_INTERRUPT_CONTROL_ZERO:   intc_d    = bus.wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			data_q <= {4{RST_DATA}};
			dir_q  <= {4{RST_DIR}};
			pu_q   <= {4{RST_PU}};
			wake_q <= RST_WAKE;
			misc_q <= RST_MISC;
			intc_q <= RST_INTC;
		end else begin
			data_q <= data_d;
			dir_q  <= dir_d;
			pu_q   <= pu_d;
			wake_q <= wake_d;
			misc_q <= misc_d;
			intc_q <= intc_d;
		end
	end

	// read path: port level taken only on the phase-two strobe of a read
	always_comb begin
		rdata_d = rdata_q;
		if (bus.rd_en && bus.phase_two) begin
			case (bus.addr)
				ADDR_PA_DATA: rdata_d = port_view(data_q[0], dir_q[0], sync2_q[7:0]);
				ADDR_PB_DATA: rdata_d = port_view(data_q[1], dir_q[1], sync2_q[15:8]);
				ADDR_PC_DATA: rdata_d = port_view(data_q[2], dir_q[2], sync2_q[23:16]);
				ADDR_PD_DATA: rdata_d = port_view(data_q[3], dir_q[3], sync2_q[31:24]);
				ADDR_PA_DIR:  rdata_d = dir_q[0];
				ADDR_PB_DIR:  rdata_d = dir_q[1];
				ADDR_PC_DIR:  rdata_d = dir_q[2];
				ADDR_PD_DIR:  rdata_d = dir_q[3];
				ADDR_PA_PU:   rdata_d = pu_q[0];
				ADDR_PB_PU:   rdata_d = pu_q[1];
				ADDR_PC_PU:   rdata_d = pu_q[2];
				ADDR_PD_PU:   rdata_d = pu_q[3];
				ADDR_PA_WAKE: rdata_d = wake_q;
				ADDR_MISC:    rdata_d = misc_q;
				ADDR_INTERRUPT_CONTROL_ZERO:   rdata_d = intc_q;
				default:      rdata_d = RD_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= RD_UNMAPPED;
		end else begin
			rdata_q <= rdata_d;
		end
	end
	assign rdata = rdata_q;

	// pin drivers: push-pull, open-drain on port a low nibble, pull-ups on inputs
	always_comb begin
		for (int i = 0; i < NUM_PORTS*PORT_W; i++) begin
			pins.out[i]    = data_q[i/8][i%8];
			pins.oe[i]     = ~dir_q[i/8][i%8];
			pins.pull_en[i] = pu_q[i/8][i%8] & dir_q[i/8][i%8];
		end
		for (int j = 0; j < 4; j++) begin
			if (misc_q[MISC_OD_LSB+j]) begin
				pins.out[j] = 1'b0;
				pins.oe[j]  = ~dir_q[0][j] & ~data_q[0][j];
			end
		end
	end

	// shared irq inputs only fed when enabled; otherwise pin is plain i/o
	assign ext_irq_zero = intc_q[INTC_EINT0_BIT] & sync2_q[EXT_IRQ_PIN_ZERO_PIN];
	assign ext_irq_one  = intc_q[INTC_EINT1_BIT] & sync2_q[EXT_IRQ_PIN_ONE_PIN];
	assign wdt_ctrl     = misc_q[MISC_WDT_W-1:0];

	// falling edge on a wake-enabled port a pin
	assign pa_fall = pa_prev_q & ~sync2_q[7:0] & wake_q;

	// power-down state machine
	always_comb begin
		pwr_d     = pwr_q;
		pa_prev_d = sync2_q[7:0];
		case (pwr_q)
			PWR_RUN:  if (halt_req) pwr_d = PWR_DOWN;
			PWR_DOWN: if (|pa_fall) pwr_d = PWR_WAKE;
			PWR_WAKE: pwr_d = PWR_RUN;
			default:  pwr_d = PWR_RUN;
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pwr_q     <= PWR_RUN;
			pa_prev_q <= 8'h00;
		end else begin
			pwr_q     <= pwr_d;
			pa_prev_q <= pa_prev_d;
		end
	end
	assign power_down = (pwr_q == PWR_DOWN);
	assign wake_pulse = (pwr_q == PWR_WAKE);

	a_reset_ones: assert property (@(posedge clk_sys) $rose(reset_n) |->
		(data_q == {4{RST_DATA}}) && (dir_q == {4{RST_DIR}}))
		else $error("ports not all ones after reset");
	a_output_drive: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!dir_q[1][0] |-> pins.oe[8] && pins.out[8] == data_q[1][0])
		else $error("output pin not driven from latch");
	a_input_float: assert property (@(posedge clk_sys) disable iff (!reset_n)
		dir_q[2][3] |-> !pins.oe[19])
		else $error("input pin driven");
	a_pullup_input: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!dir_q[1][0] |-> !pins.pull_en[8])
		else $error("pull-up on output pin");
	a_read_latch: assert property (@(posedge clk_sys) disable iff (!reset_n)
		bus.rd_en && bus.phase_two && bus.addr == ADDR_PA_DATA && dir_q[0] == 8'h00
		|=> rdata == $past(data_q[0]))
		else $error("output read not from latch");
	a_latch_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!(bus.wr_en && bus.addr == ADDR_PC_DATA) |=> data_q[2] == $past(data_q[2]))
		else $error("latch changed without write");
	a_od_release: assert property (@(posedge clk_sys) disable iff (!reset_n)
		misc_q[MISC_OD_LSB] && data_q[0][0] |-> !pins.oe[0])
		else $error("open-drain high not released");
	sequence s_asleep;
		pwr_q == PWR_DOWN && pa_fall == 8'h00;
	endsequence
	a_stay_down: assert property (@(posedge clk_sys) disable iff (!reset_n)
		s_asleep |=> pwr_q == PWR_DOWN)
		else $error("woke without selected falling edge");
	// one wake cycle, then back to run
	sequence s_woken;
		wake_pulse ##1 pwr_q == PWR_RUN;
	endsequence
	a_wake_seq: assert property (@(posedge clk_sys) disable iff (!reset_n)
		pwr_q == PWR_DOWN && |pa_fall |=> s_woken)
		else $error("wake sequence wrong");
	a_irq_gate: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!intc_q[INTC_EINT0_BIT] |-> !ext_irq_zero)
		else $error("irq passed while disabled");
endmodule

/* fpg_pin_model.sv */
`timescale 1ns/1ps
// switches and loose wires on the 32 port pins
module fpg_pin_model (
	input  wire logic        clk_sys,
	input  wire logic [31:0] out,
	input  wire logic [31:0] oe,
	input  wire logic [31:0] pull_en,
	input  wire logic [31:0] ext_en,
	input  wire logic [31:0] ext_val,
	output logic [31:0]      level
);
	logic [31:0] float_q = '0;
	// a pin nobody holds wanders every cycle
	always_ff @(posedge clk_sys) begin
		float_q <= ~level;
	end
	// device drive wins, then a switch, then the weak pull-up
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			level[i] = oe[i] ? out[i] : ext_en[i] ? ext_val[i] : pull_en[i] ? 1'b1 : float_q[i];
		end
	end
endmodule

/* fpg_pkg.sv */
package fpg_pkg;
	localparam int       NUM_PORTS   = 4;
	localparam int       PORT_W      = 8;
	// register index for each addressable location (data memory offsets of own choosing)
	localparam logic [4:0] ADDR_PA_DATA   = 5'h00;
	localparam logic [4:0] ADDR_PA_DIR    = 5'h01;
	localparam logic [4:0] ADDR_PB_DATA   = 5'h02;
	localparam logic [4:0] ADDR_PB_DIR    = 5'h03;
	localparam logic [4:0] ADDR_PC_DATA   = 5'h04;
	localparam logic [4:0] ADDR_PC_DIR    = 5'h05;
	localparam logic [4:0] ADDR_PD_DATA   = 5'h06;
	localparam logic [4:0] ADDR_PD_DIR    = 5'h07;
	localparam logic [4:0] ADDR_PA_PU     = 5'h08;
	localparam logic [4:0] ADDR_PB_PU     = 5'h09;
	localparam logic [4:0] ADDR_PC_PU     = 5'h0a;
	localparam logic [4:0] ADDR_PD_PU     = 5'h0b;
	localparam logic [4:0] ADDR_PA_WAKE   = 5'h0c;
	localparam logic [4:0] ADDR_MISC      = 5'h0d;
	localparam logic [4:0] ADDR_INTERRUPT_CONTROL_ZERO     = 5'h0e;
	// field positions
	localparam int       MISC_OD_LSB    = 4;
	localparam int       MISC_WDT_W     = 4;
	localparam int       INTC_EINT0_BIT = 1;
	localparam int       INTC_EINT1_BIT = 2;
	localparam int       EXT_IRQ_PIN_ZERO_PIN       = 0;   // pin of port a shared with irq input zero
	localparam int       EXT_IRQ_PIN_ONE_PIN       = 1;
	// reset values
	localparam logic [7:0] RST_DATA  = 8'hff;
	localparam logic [7:0] RST_DIR   = 8'hff;
	localparam logic [7:0] RST_PU    = 8'h00;
	localparam logic [7:0] RST_WAKE  = 8'h00;
	localparam logic [7:0] RST_MISC  = 8'h00;
	localparam logic [7:0] RST_INTC  = 8'h00;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;

	typedef struct packed {
		logic       wr_en;
		logic       rd_en;
		logic       phase_two;
		logic [4:0] addr;
		logic [7:0] wdata;
	} fpg_bus_type;

	typedef struct packed {
		logic [NUM_PORTS*PORT_W-1:0] out;
		logic [NUM_PORTS*PORT_W-1:0] oe;
		logic [NUM_PORTS*PORT_W-1:0] pull_en;
	} fpg_pins_type;

	typedef enum logic [1:0] {
		PWR_RUN   = 2'b00,
		PWR_DOWN  = 2'b01,
		PWR_WAKE  = 2'b11
	} fpg_pwr_type;
endpackage

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
	import fpg_pkg::*;
	logic         clk_sys = 1'b0;
	logic         reset_n = 1'b0;
	logic         halt_req = 1'b0;
	fpg_bus_type  bus = '0;
	logic [31:0]  ext_en = '0;
	logic [31:0]  ext_val = '0;
	logic [31:0]  pin_in;
	fpg_pins_type pins;
	logic [7:0]   rdata;
	logic [3:0]   wdt_ctrl;
	logic         power_down, wake_pulse, irq0, irq1, seen;
	int           fails = 0, num_checks = 0, cycles = 0;

	fpg_gpio dut (.clk_sys(clk_sys), .reset_n(reset_n), .bus(bus), .rdata(rdata),
		.halt_req(halt_req), .pin_in(pin_in), .pins(pins), .power_down(power_down),
		.wake_pulse(wake_pulse), .ext_irq_zero(irq0), .ext_irq_one(irq1), .wdt_ctrl(wdt_ctrl));
	fpg_pin_model model (.clk_sys(clk_sys), .out(pins.out), .oe(pins.oe), .pull_en(pins.pull_en),
		.ext_en(ext_en), .ext_val(ext_val), .level(pin_in));

	always #20 clk_sys = ~clk_sys;

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		bus.wr_en <= 1'b1;
		bus.addr <= a;
		bus.wdata <= d;
		@(posedge clk_sys);
		bus.wr_en <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		bus.rd_en <= 1'b1;
		bus.phase_two <= 1'b1;
		bus.addr <= a;
		@(posedge clk_sys);
		bus.rd_en <= 1'b0;
		bus.phase_two <= 1'b0;
		@(posedge clk_sys);
		#1;
		check({24'h0, rdata}, {24'h0, exp});
	endtask
	task automatic waitc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic test_done();
		if (fails == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// reset state and an unmapped read
	task automatic t_reset();
		check(pins.oe, 32'h0);
		rd(ADDR_PA_DIR, 8'hff);
		rd(ADDR_PA_PU, 8'h00);
		rd(ADDR_PD_DIR, 8'hff);
		rd(5'h1f, RD_UNMAPPED);
	endtask
	// push-pull output from the latch
	task automatic t_out();
		wr(ADDR_PA_DIR, 8'h00);
		check(pins.out[7:0], 8'hff);
		wr(ADDR_PA_DATA, 8'ha5);
		check({pins.oe[7:0], pins.out[7:0]}, 16'hffa5);
		waitc(5);
		rd(ADDR_PA_DATA, 8'ha5);
	endtask
	// open drain on the low nibble, read shows latch not pin
	task automatic t_od();
		wr(ADDR_MISC, 8'hf3);
		wr(ADDR_PA_DATA, 8'h0a);
		check({wdt_ctrl, pins.oe[7:0], pins.out[3:0]}, 16'h3f50);
		ext_en[7:0] <= 8'h0a;
		waitc(4);
		rd(ADDR_PA_DATA, 8'h0a);
		ext_en[7:0] <= 8'h00;
		wr(ADDR_MISC, 8'h00);
	endtask
	// unlatched input, pull-up and single direction changes
	task automatic t_in();
		wr(ADDR_PB_DIR, 8'hff);
		ext_en[15:8] <= 8'hff;
		ext_val[15:8] <= 8'h3c;
		waitc(4);
		rd(ADDR_PB_DATA, 8'h3c);
		ext_val[15:8] <= 8'hc3;
		waitc(4);
		rd(ADDR_PB_DATA, 8'hc3);
		wr(ADDR_PB_PU, 8'hff);
		check(pins.pull_en[15:8], 8'hff);
		wr(ADDR_PB_DIR, 8'hf0);
		check(pins.pull_en[15:8], 8'hf0);
		rd(ADDR_PB_DATA, 8'hcf);
	endtask
	// halt, ignore an unselected fall, wake on a selected one
	task automatic t_wake();
		wr(ADDR_PA_DIR, 8'hff);
		ext_en[7:0] <= 8'hff;
		ext_val[7:0] <= 8'hff;
		wr(ADDR_PA_WAKE, 8'h04);
		waitc(4);
		@(posedge clk_sys);
		halt_req <= 1'b1;
		@(posedge clk_sys);
		halt_req <= 1'b0;
		waitc(2);
		check(power_down, 1'b1);
		ext_val[1] <= 1'b0;
		waitc(8);
		check({wake_pulse, power_down}, 2'b01);
		ext_val[2] <= 1'b0;
		seen = 1'b0;
		for (int i = 0; i < 8 && !seen; i++) begin
			waitc(1);
			seen = (wake_pulse === 1'b1);
		end
		check(seen, 1'b1);
		waitc(2);
		check(power_down, 1'b0);
	endtask
	// irq sharing on pins a0 and a1
	task automatic t_irq();
		ext_val[7:0] <= 8'hff;
		wr(ADDR_INTERRUPT_CONTROL_ZERO, 8'h02);
		waitc(4);
		check({irq0, irq1}, 2'b10);
		wr(ADDR_INTERRUPT_CONTROL_ZERO, 8'h04);
		waitc(3);
		check({irq0, irq1}, 2'b01);
	endtask

	// hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			test_done();
		end
	end

	initial begin
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		t_reset();
		t_out();
		t_od();
		t_in();
		t_wake();
		t_irq();
		test_done();
	end
endmodule
